/* rtl/lsa_regs.vh */
`ifndef LSA_REGS_VH
`define LSA_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define LSA_IDX_CTRL 6'h01
`define LSA_IDX_STAT 6'h02
`define LSA_IDX_ENT1 6'h05
`define LSA_IDX_ENT2 6'h06
`define LSA_IDX_ENT3 6'h07
`define LSA_IDX_ENT4 6'h08
`define LSA_IDX_ENT5 6'h09

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define LSA_CTRL_SMPTE 0
`define LSA_CTRL_RATE 1
`define LSA_CTRL_MUX10 2
`define LSA_CTRL_RST 3'h0
`define LSA_ENT_RST 16'h0000
`define LSA_STAT_LUMA 0
`define LSA_STAT_CHROMA 1
`define LSA_STAT_EMPTY 2
`define LSA_STAT_FULL 3
`define LSA_EDH_LO 8
`define LSA_EDH_HI 15

// ****************************************************************
// Stream code words
// ****************************************************************
`define LSA_WORD_ZERO 10'h000
`define LSA_WORD_ONES 10'h3FF
`define LSA_XYZ_H 6
`define LSA_ANC_TAIL 9'h006
`define LSA_WIN_LAST 5

`endif

/* rtl/lsa_top.v */
// How it works
// RULE1 - Line FIFO reset rests high, drops low exactly one word clock; here it stays low until the XYZ word is taken.
// RULE2 - Low pulse sits on the SAV XYZ word; next word is first active sample.
// RULE3 - Ancillary packets found in any blanking region are marked by luma/chroma flags.
// RULE4 - Both ancillary flags are registered on the word clock.
// RULE5 - High-definition: each flag follows ancillary data in its own channel.
// RULE6 - Standard-definition 20-bit: flags generated independently per channel.
// RULE7 - Standard-definition 10-bit: both flags rise together on any packet.
// RULE8 - Flag high from first preamble word through checksum word.
// RULE9 - Five host-writable match entries select flagged packet types.
// RULE10 - Entry upper byte is identifier, lower byte secondary identifier.
// RULE11 - With filtering, flag only packets exactly matching nonzero programmed bytes.
// RULE12 - A zero identifier byte is a wildcard and skips its comparison.
// RULE13 - All entries zero, the reset state, flags every packet.
// RULE14 - Some entries programmed: only matching packets flagged, others ignored.
// RULE15 - Error-check packets always detected, whatever the filter says.
// RULE16 - Host writes zero secondary byte when a packet type has none.
// RULE17 - Pulse and detection only run in SMPTE video mode.
// RULE18 - Entries are ORed; entries with both bytes zero take no part.
`default_nettype none
`include "lsa_regs.vh"

// ****************************************************************
// Word FIFO
// ****************************************************************
module lsa_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i, // Word clock
  input wire rst_i, // Sync reset, high
  input wire in_valid_i, // Word offered
  input wire [WIDTH-1:0] in_data_i, // Word in
  output reg in_ready_o, // Room for a word
  output reg out_valid_o, // Word available
  output wire [WIDTH-1:0] out_data_o, // Head word
  input wire out_ready_i // Head taken
);
  localparam integer LAST_I = DEPTH - 1;
  localparam integer FULL_I = DEPTH;
  localparam [AW-1:0] LAST = LAST_I[AW-1:0];
  localparam [AW:0] FULLC = FULL_I[AW:0];
  // Storage has no reset; pointers and count alone say what is valid
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  wire push;
  wire pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      next_count = count - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      // Flags follow the next count so both stay registered
      count <= next_count;
      in_ready_o <= (next_count != FULLC);
      out_valid_o <= (next_count != {(AW+1){1'b0}});
    end
  end
endmodule

// ****************************************************************
// Line pulse and ancillary detect, Wishbone slave
// ****************************************************************
module lsa_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter [7:0] EDH_DID = 8'hF4
) (
  input wire clk_i, // Parallel word clock
  input wire rst_i, // Sync reset, high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte lanes
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire in_valid_i, // Stream word offered
  input wire [19:0] in_data_i, // Luma 19:10, chroma 9:0
  output wire in_ready_o, // Stream can take a word
  output reg out_valid_o, // Output word valid
  output reg [19:0] out_data_o, // Output word
  input wire out_ready_i, // Downstream takes word
  output reg line_fifo_reset_n_o, // Line FIFO write reset, low
  output reg luma_anc_flag_o, // Luma ancillary marker
  output reg chroma_anc_flag_o // Chroma ancillary marker
);
  reg [2:0] ctrl;
  reg [15:0] anc_match_entry_one;
  reg [15:0] anc_match_entry_two;
  reg [15:0] anc_match_entry_three;
  reg [15:0] anc_match_entry_four;
  reg [15:0] anc_match_entry_five;
  reg [7:0] edh_count;
  reg [19:0] win [0:`LSA_WIN_LAST];
  reg [`LSA_WIN_LAST:0] win_vld;
  reg [2:0] sav_sh;
  reg [8:0] luma_cnt;
  reg [8:0] chroma_cnt;
  reg [31:0] next_rdata;
  wire fifo_valid;
  wire fifo_empty_n;
  wire [19:0] fifo_data;
  wire step;
  wire smpte_mode;
  wire rate_select_low_high_def;
  wire sd_mux10;
  wire [5:0] wb_idx;
  wire wb_req;
  wire [79:0] entries;
  wire luma_start;
  wire chroma_start;
  wire luma_hit;
  wire chroma_hit;
  wire luma_now;
  wire chroma_now;
  wire sav_now;
  integer i;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function is_preamble;
    input [9:0] a;
    input [9:0] b;
    input [9:0] c;
    begin
      is_preamble = (a == `LSA_WORD_ZERO) && (b == `LSA_WORD_ONES) && (c == `LSA_WORD_ONES);
    end
  endfunction

  function anc_hit;
    input [7:0] did;
    input [7:0] sdid;
    input [79:0] tbl;
    integer k;
    reg any;
    reg hit;
    reg [15:0] e;
    begin
      any = 1'b0;
      hit = 1'b0;
      for (k = 0; k < 5; k = k + 1) begin
        e = tbl[k*16 +: 16];
        if (e != `LSA_ENT_RST) begin // RULE18
          any = 1'b1;
          // A zero byte skips its compare; a nonzero byte must match exactly
          if ((e[15:8] == 8'h00 || e[15:8] == did) &&
              (e[7:0] == 8'h00 || e[7:0] == sdid)) begin // RULE10 RULE11 RULE12
            hit = 1'b1; // RULE18
          end
        end
      end
      anc_hit = ~any | hit; // RULE13 RULE14
    end
  endfunction

  // ****************************************************************
  // Control decode
  // ****************************************************************
  assign smpte_mode = ctrl[`LSA_CTRL_SMPTE];
  assign rate_select_low_high_def = ctrl[`LSA_CTRL_RATE];
  assign sd_mux10 = rate_select_low_high_def & ctrl[`LSA_CTRL_MUX10];
  assign entries = {anc_match_entry_five, anc_match_entry_four, anc_match_entry_three,
                    anc_match_entry_two, anc_match_entry_one};

  // ****************************************************************
  // Stream path
  // ****************************************************************
  lsa_fifo #(
    .WIDTH(20),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(in_valid_i),
    .in_data_i(in_data_i),
    .in_ready_o(in_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(step)
  );

  assign fifo_empty_n = fifo_valid;
  // Window moves only with a new word, so the last few words wait for the next
  assign step = fifo_valid & (out_ready_i | ~out_valid_o);

  // Lookahead window: win[0] is the next output word
  // Whole window must be valid, since the count word sits at its far end
  assign luma_start = win_vld[0] &
    is_preamble(win[0][19:10], win[1][19:10], win[2][19:10]); // RULE3
  assign chroma_start = win_vld[0] &
    is_preamble(win[0][9:0], win[1][9:0], win[2][9:0]); // RULE3
  assign luma_hit = luma_start & anc_hit(win[3][17:10], win[4][17:10], entries);
  assign chroma_hit = chroma_start & anc_hit(win[3][7:0], win[4][7:0], entries);
  assign luma_now = smpte_mode & (luma_hit | (luma_cnt != 9'h000)); // RULE8 RULE17
  assign chroma_now = smpte_mode & (chroma_hit | (chroma_cnt != 9'h000)); // RULE8 RULE17
  // Start code is found three words early and shifted to the XYZ slot
  assign sav_now = win_vld[0] &&
    (win[0][19:10] == `LSA_WORD_ONES) && (win[1][19:10] == `LSA_WORD_ZERO) &&
    (win[2][19:10] == `LSA_WORD_ZERO) && win[3][19] && !win[3][10+`LSA_XYZ_H];

  always @(posedge clk_i) begin
    if (step) begin
      for (i = 0; i < `LSA_WIN_LAST; i = i + 1) begin
        win[i] <= win[i+1];
      end
      win[`LSA_WIN_LAST] <= fifo_data;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      win_vld <= {(`LSA_WIN_LAST+1){1'b0}};
      sav_sh <= 3'h0;
      luma_cnt <= 9'h000;
      chroma_cnt <= 9'h000;
      edh_count <= 8'h00;
      out_valid_o <= 1'b0;
      out_data_o <= 20'h00000;
      line_fifo_reset_n_o <= 1'b1;
      luma_anc_flag_o <= 1'b0;
      chroma_anc_flag_o <= 1'b0;
    end else begin
      if (out_ready_i) begin
        out_valid_o <= 1'b0;
        line_fifo_reset_n_o <= 1'b1; // RULE1
        luma_anc_flag_o <= 1'b0;
        chroma_anc_flag_o <= 1'b0;
      end
      if (step) begin
        win_vld <= {1'b1, win_vld[`LSA_WIN_LAST:1]};
        sav_sh <= {sav_sh[1:0], sav_now & smpte_mode};
        out_valid_o <= win_vld[0];
        out_data_o <= win[0];
        line_fifo_reset_n_o <= ~(win_vld[0] & smpte_mode & sav_sh[2]); // RULE1 RULE2 RULE17
        // 10-bit multiplex is one stream, so either lane's packet raises both flags
        luma_anc_flag_o <= win_vld[0] & (luma_now | (sd_mux10 & chroma_now)); // RULE4 RULE5 RULE6 RULE7
        chroma_anc_flag_o <= win_vld[0] & (chroma_now | (sd_mux10 & luma_now)); // RULE4 RULE5 RULE6 RULE7
        if (!smpte_mode) begin
          luma_cnt <= 9'h000;
        end else if (luma_hit) begin
          luma_cnt <= {1'b0, win[5][17:10]} + `LSA_ANC_TAIL; // RULE8
        end else if (luma_cnt != 9'h000) begin
          luma_cnt <= luma_cnt - 9'h001;
        end
        if (!smpte_mode) begin
          chroma_cnt <= 9'h000;
        end else if (chroma_hit) begin
          chroma_cnt <= {1'b0, win[5][7:0]} + `LSA_ANC_TAIL; // RULE8
        end else if (chroma_cnt != 9'h000) begin
          chroma_cnt <= chroma_cnt - 9'h001;
        end
        // Error packets counted before and apart from the filter
        if (smpte_mode && ((luma_start && win[3][17:10] == EDH_DID) ||
            (chroma_start && win[3][7:0] == EDH_DID))) begin
          edh_count <= edh_count + 8'h01; // RULE15
        end
      end
    end
  end

  // ****************************************************************
  // Wishbone registers
  // ****************************************************************
  assign wb_idx = wb_adr_i[7:2];
  assign wb_req = wb_cyc_i & wb_stb_i;

  always @* begin
    next_rdata = 32'h00000000;
    case (wb_idx)
      `LSA_IDX_CTRL: next_rdata[2:0] = ctrl;
      `LSA_IDX_STAT: begin
        next_rdata[`LSA_STAT_LUMA] = luma_anc_flag_o;
        next_rdata[`LSA_STAT_CHROMA] = chroma_anc_flag_o;
        next_rdata[`LSA_STAT_EMPTY] = ~fifo_empty_n;
        next_rdata[`LSA_STAT_FULL] = ~in_ready_o;
        next_rdata[`LSA_EDH_HI:`LSA_EDH_LO] = edh_count;
      end
      `LSA_IDX_ENT1: next_rdata[15:0] = anc_match_entry_one;
      `LSA_IDX_ENT2: next_rdata[15:0] = anc_match_entry_two;
      `LSA_IDX_ENT3: next_rdata[15:0] = anc_match_entry_three;
      `LSA_IDX_ENT4: next_rdata[15:0] = anc_match_entry_four;
      `LSA_IDX_ENT5: next_rdata[15:0] = anc_match_entry_five;
      default: next_rdata = 32'h00000000;
    endcase
  end

  function [15:0] lane_write;
    input [15:0] old;
    input [15:0] data;
    input [1:0] sel;
    begin
      lane_write = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl <= `LSA_CTRL_RST;
      anc_match_entry_one <= `LSA_ENT_RST; // RULE13
      anc_match_entry_two <= `LSA_ENT_RST;
      anc_match_entry_three <= `LSA_ENT_RST;
      anc_match_entry_four <= `LSA_ENT_RST;
      anc_match_entry_five <= `LSA_ENT_RST;
    end else begin
      // Ack drops for a cycle even if the strobe stays, so one request acks once
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        wb_dat_o <= next_rdata;
      end
      // Write lands on the edge where the master sees ack
      if (wb_req && wb_we_i && wb_ack_o) begin
        case (wb_idx)
          `LSA_IDX_CTRL: begin
            if (wb_sel_i[0]) begin
              ctrl <= wb_dat_i[2:0];
            end
          end
          `LSA_IDX_ENT1: anc_match_entry_one <= lane_write(anc_match_entry_one, wb_dat_i[15:0],
                                                           wb_sel_i[1:0]); // RULE9
          `LSA_IDX_ENT2: anc_match_entry_two <= lane_write(anc_match_entry_two, wb_dat_i[15:0],
                                                           wb_sel_i[1:0]); // RULE9
          `LSA_IDX_ENT3: anc_match_entry_three <= lane_write(anc_match_entry_three, wb_dat_i[15:0],
                                                             wb_sel_i[1:0]); // RULE9
          `LSA_IDX_ENT4: anc_match_entry_four <= lane_write(anc_match_entry_four, wb_dat_i[15:0],
                                                            wb_sel_i[1:0]); // RULE9
          `LSA_IDX_ENT5: anc_match_entry_five <= lane_write(anc_match_entry_five, wb_dat_i[15:0],
                                                            wb_sel_i[1:0]); // RULE9
          default: ctrl <= ctrl;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* tb/lsa_top_asserts.sv */
`default_nettype none
module lsa_top_asserts (
  input wire logic clk_i, // Word clock
  input wire logic rst_i, // Sync reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus ack
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic in_ready_o, // Input room
  input wire logic out_valid_o, // Word valid
  input wire logic [19:0] out_data_o, // Word
  input wire logic out_ready_i, // Sink ready
  input wire logic line_fifo_reset_n_o, // Line reset
  input wire logic luma_anc_flag_o, // Luma flag
  input wire logic chroma_anc_flag_o // Chroma flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pulse_one_a: assert property (!line_fifo_reset_n_o && out_ready_i |=> line_fifo_reset_n_o)
    else $error("line reset low beyond one word");
  pulse_xyz_a: assert property (!line_fifo_reset_n_o |-> out_valid_o && out_data_o[19] && !out_data_o[16])
    else $error("line reset not on a start code word");
  rst_idle_a: assert property (disable iff (1'b0) rst_i |=> line_fifo_reset_n_o && !out_valid_o)
    else $error("outputs not idle after reset");
  flag_word_a: assert property (luma_anc_flag_o || chroma_anc_flag_o |-> out_valid_o)
    else $error("flag without a word");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
    && $stable(luma_anc_flag_o))
    else $error("stalled word changed");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  rdata_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o))
    else $error("read data changed while idle");
  cover property (!line_fifo_reset_n_o);
  cover property (luma_anc_flag_o && chroma_anc_flag_o);
  cover property (!in_ready_o);
endmodule
`default_nettype wire

/* tb/lsa_sink.sv */
`default_nettype none
module lsa_sink (
  input wire logic clk_i, // Word clock
  input wire logic rst_i, // Sync reset
  input wire logic hold_i, // Stall fully
  input wire logic valid_i, // Word valid
  input wire logic [19:0] data_i, // Word
  input wire logic rst_n_i, // Line reset
  input wire logic luma_i, // Luma flag
  input wire logic chroma_i, // Chroma flag
  output logic ready_o, // Takes word
  output logic [15:0] n_word_o, // Words taken
  output logic [15:0] n_luma_o, // Luma flagged
  output logic [15:0] n_chroma_o, // Chroma flagged
  output logic [15:0] n_rst_o, // Reset pulses
  output logic [9:0] rst_luma_o, // Luma at pulse
  output logic [9:0] last_luma_o // Last luma flagged
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph;
  // Stall one cycle in four so held words get exercised
  assign ready_o = !hold_i && ph != 2'h3;
  always @(posedge clk_i) begin
    ph <= rst_i ? 2'h0 : ph + 2'h1;
    if (rst_i) begin
      n_word_o <= 16'h0;
      n_luma_o <= 16'h0;
      n_chroma_o <= 16'h0;
      n_rst_o <= 16'h0;
      rst_luma_o <= 10'h0;
      last_luma_o <= 10'h0;
    end else if (valid_i && ready_o) begin
      n_word_o <= n_word_o + 16'h1;
      n_luma_o <= n_luma_o + {15'h0, luma_i};
      n_chroma_o <= n_chroma_o + {15'h0, chroma_i};
      n_rst_o <= n_rst_o + {15'h0, !rst_n_i};
      if (!rst_n_i) rst_luma_o <= data_i[19:10];
      if (luma_i) last_luma_o <= data_i[19:10];
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic in_valid_i = 1'b0, hold = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [19:0] in_data_i = 20'h0;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, in_ready_o, out_valid_o, out_ready_i, line_fifo_reset_n_o, luma_anc_flag_o, chroma_anc_flag_o;
  wire logic [19:0] out_data_o;
  wire logic [15:0] n_word, n_luma, n_chroma, n_rst;
  wire logic [9:0] rst_luma, last_luma;
  int errors = 0, n_compared = 0, tot = 0;
  logic [19:0] q[$];
  // ****************
  // Harness
  // ****************
  always #2 clk_i = ~clk_i;
  lsa_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .in_valid_i, .in_data_i, .in_ready_o, .out_valid_o, .out_data_o, .out_ready_i,
    .line_fifo_reset_n_o, .luma_anc_flag_o, .chroma_anc_flag_o);
  lsa_sink u_sink (.clk_i, .rst_i, .hold_i(hold), .valid_i(out_valid_o), .data_i(out_data_o),
    .rst_n_i(line_fifo_reset_n_o), .luma_i(luma_anc_flag_o), .chroma_i(chroma_anc_flag_o), .ready_o(out_ready_i),
    .n_word_o(n_word), .n_luma_o(n_luma), .n_chroma_o(n_chroma), .n_rst_o(n_rst), .rst_luma_o(rst_luma),
    .last_luma_o(last_luma));
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("unexpected timeout expected 0 seen 1");
    print_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] idx, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= s;
    wb_dat_i <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (k == 50) tmo();
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] r;
    wb(1'b1, idx, s, d, r);
  endtask
  task automatic rd(input string nm, input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, idx, 4'hF, 32'h0, r);
    chk(nm, e, r & m);
  endtask
  task automatic push(input logic [19:0] w);
    int k;
    in_valid_i <= 1'b1;
    in_data_i <= w;
    for (k = 0; k < 100; k++) begin
      @(posedge clk_i);
      if (in_ready_o === 1'b1) break;
    end
    if (k == 100) tmo();
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 400 && n_word != 16'(tot - 6); k++) @(posedge clk_i);
    if (k == 400) tmo();
  endtask
  task automatic anc(input bit ch, input logic [7:0] did, input logic [7:0] sdid);
    logic [9:0] w[8];
    w = '{10'h000, 10'h3FF, 10'h3FF, {2'h1, did}, {2'h1, sdid}, 10'h201, 10'h155, 10'h0AA};
    foreach (w[i]) q.push_back(ch ? {10'h040, w[i]} : {w[i], 10'h200});
  endtask
  task automatic sav();
    q.push_back(20'hFFE00);
    q.push_back(20'h00200);
    q.push_back(20'h00200);
    q.push_back(20'h80200);
    q.push_back(20'h40100);
  endtask
  // Six trailing fillers push every packet word past the lookahead
  task automatic run(input string nm, input int el, input int ec, input int er);
    logic [15:0] l0, c0, r0;
    l0 = n_luma;
    c0 = n_chroma;
    r0 = n_rst;
    repeat (6) q.push_back(20'h10200);
    tot += q.size();
    while (q.size() > 0) push(q.pop_front());
    in_valid_i <= 1'b0;
    drain();
    chk({nm, " luma count"}, el, 32'(n_luma - l0));
    chk({nm, " chroma count"}, ec, 32'(n_chroma - c0));
    chk({nm, " pulse count"}, er, 32'(n_rst - r0));
    $display("test %s done", nm);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    for (int i = 5; i < 10; i++) rd("entry reset", 6'(i), 32'hFFFF, 32'h0);
    rd("ctrl reset", 6'h01, 32'hFFFF, 32'h0);
    wr(6'h07, 32'hABCD);
    rd("entry three", 6'h07, 32'hFFFFFFFF, 32'hABCD);
    wr(6'h07, 32'h1234, 4'h1);
    rd("entry lane", 6'h07, 32'hFFFFFFFF, 32'hAB34);
    wr(6'h07, 32'h0);
    rd("unmapped", 6'h30, 32'hFFFFFFFF, 32'h0);
    wr(6'h02, 32'hFF00);
    rd("status count", 6'h02, 32'hFF00, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_modes();
    sav();
    anc(0, 8'h41, 8'h05);
    run("off", 0, 0, 0);
    wr(6'h01, 32'h1);
    sav();
    anc(0, 8'h41, 8'h05);
    anc(1, 8'h51, 8'h02);
    run("hd", 8, 8, 1);
    chk("pulse word", 32'h200, {22'h0, rst_luma});
    chk("luma last word", 32'h0AA, {22'h0, last_luma});
    wr(6'h01, 32'h3);
    anc(1, 8'h41, 8'h05);
    run("sd20", 0, 8, 0);
    wr(6'h01, 32'h7);
    anc(0, 8'h41, 8'h05);
    run("sd10", 8, 8, 0);
  endtask
  task automatic t_filter();
    wr(6'h01, 32'h1);
    wr(6'h05, 32'h4100);
    wr(6'h06, 32'h6007);
    anc(0, 8'h41, 8'h05);
    anc(0, 8'h42, 8'h05);
    anc(0, 8'h60, 8'h08);
    anc(0, 8'h60, 8'h07);
    anc(0, 8'hF4, 8'h00);
    run("filter", 16, 0, 0);
    rd("check packets", 6'h02, 32'hFF00, 32'h100);
    wr(6'h05, 32'h0);
    wr(6'h06, 32'h0);
  endtask
  task automatic t_full();
    int k;
    int acc;
    acc = 0;
    hold <= 1'b1;
    in_valid_i <= 1'b1;
    in_data_i <= 20'h10200;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_i);
      if (in_ready_o !== 1'b1) break;
      acc++;
    end
    in_valid_i <= 1'b0;
    tot += acc;
    chk("refused", 32'h1, 32'(k < 40));
    rd("full bit", 6'h02, 32'h8, 32'h8);
    hold <= 1'b0;
    drain();
    rd("empty bit", 6'h02, 32'h4, 32'h4);
    $display("test full done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_modes();
    t_filter();
    t_full();
    print_verdict();
  end
endmodule
bind lsa_top lsa_top_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .in_ready_o,
  .out_valid_o, .out_data_o, .out_ready_i, .line_fifo_reset_n_o, .luma_anc_flag_o, .chroma_anc_flag_o);
`default_nettype wire
